// >>> logic/ofs_top.sv
// oscillator manual enables, frequency select and trim behind an avalon slave
//
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
// Notes on behaviour
// - a set external manual bit forces the external oscillator on in its configured mode.
// - a set fast internal manual bit keeps that oscillator on at the selected frequency.
// - a set slow internal manual bit forces the 31 kHz oscillator on.
// - a set secondary manual bit forces the secondary oscillator on.
// - a set converter manual bit forces the 600 kHz oscillator on.
// - the top four frequency select bits ignore writes and read as zero.
// - with the internal source chosen the code gives 1, 2, 4, 8, 12, 16 or 32 MHz, 0010 reserved.
// - with the doubled source chosen codes 0100 to 0110 give 16, 24 and 32 MHz, others reserved.
// - the six bit trim moves the fast oscillator, zero being centre and reset value.
module ofs_top (
  input  wire logic                          CLK,
  input  wire logic                          RST,
  input  wire logic [ofs_pkg::ADDR_W-1:0]    ADDRESS,
  input  wire logic                          READ,
  input  wire logic                          WRITE,
  input  wire logic [ofs_pkg::DATA_W-1:0]    WRITEDATA,
  input  wire logic [3:0]                    BYTEENABLE,
  output logic      [ofs_pkg::DATA_W-1:0]    READDATA,
  output logic                               WAITREQUEST,
  input  wire logic [ofs_pkg::NUM_OSC-1:0]   PERIPH_REQ,
  input  wire logic [ofs_pkg::SRC_W-1:0]     NEW_SOURCE_SELECT,
  input  wire logic [ofs_pkg::MODE_W-1:0]    EXT_OSC_MODE_CONFIG,
  output logic [ofs_pkg::NUM_OSC-1:0]        OSC_ENABLE,
  output logic [ofs_pkg::MODE_W-1:0]         EXT_OSC_MODE,
  output logic [ofs_pkg::CODE_W-1:0]         FAST_OSC_FREQ_CODE,
  output logic [ofs_pkg::MHZ_W-1:0]          FAST_OSC_MHZ,
  output logic                               FAST_OSC_PLL_2X,
  output logic                               FAST_OSC_RESERVED,
  output logic [ofs_pkg::TRIM_W-1:0]         FAST_OSC_TRIM,
  output logic [ofs_pkg::TRIM_W-1:0]         FAST_OSC_TRIM_LEVEL
);
  import ofs_pkg::*;

  logic [REG_W-1:0]   oscillator_manual_enable;
  logic [REG_W-1:0]   internal_osc_frequency_select;
  logic [REG_W-1:0]   internal_osc_tuning;
  logic [NUM_OSC-1:0] req_meta;
  logic [NUM_OSC-1:0] req_sync;
  logic [SRC_W-1:0]   src_meta;
  logic [SRC_W-1:0]   src_sync;
  logic [MODE_W-1:0]  mode_meta;
  logic [MODE_W-1:0]  mode_sync;
  logic [NUM_OSC-1:0] force_on;
  logic [NUM_OSC-1:0] next_enable;
  logic               wr_take;
  logic [REG_W-1:0]   wr_byte;
  logic [REG_W-1:0]   next_readback;
  logic [REG_W-1:0]   status;

  ofs_freq_if freq ();

  ofs_freq_decode u_decode (
    .f (freq)
  );

  // masked write of lane 0 onto an 8-bit register
  function automatic logic [REG_W-1:0] merge(
    input logic [REG_W-1:0] old_val,
    input logic [REG_W-1:0] new_val,
    input logic [REG_W-1:0] mask
  );
    merge = (old_val & ~mask) | (new_val & mask);
  endfunction

  // external inputs pass two flip-flops before use
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      req_meta  <= '0;
      req_sync  <= '0;
      src_meta  <= SRC_FAST_INT;
      src_sync  <= SRC_FAST_INT;
      mode_meta <= '0;
      mode_sync <= '0;
    end else begin
      req_meta  <= PERIPH_REQ;
      req_sync  <= req_meta;
      src_meta  <= NEW_SOURCE_SELECT;
      src_sync  <= src_meta;
      mode_meta <= EXT_OSC_MODE_CONFIG;
      mode_sync <= mode_meta;
    end
  end

  // one wait cycle, then a single cycle with waitrequest low
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      WAITREQUEST <= 1'b1;
    end else if ((READ || WRITE) && WAITREQUEST) begin
      WAITREQUEST <= 1'b0;
    end else begin
      WAITREQUEST <= 1'b1;
    end
  end

  assign wr_take = WRITE && !WAITREQUEST && BYTEENABLE[0];
  assign wr_byte = WRITEDATA[REG_W-1:0];

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      oscillator_manual_enable <= RST_MANUAL_ENABLE;
    end else if (wr_take && ADDRESS == OFS_MANUAL_ENABLE) begin
      oscillator_manual_enable <= merge(oscillator_manual_enable, wr_byte, MASK_MANUAL_ENABLE);
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      internal_osc_frequency_select <= RST_FREQ_SELECT;
    end else if (wr_take && ADDRESS == OFS_FREQ_SELECT) begin
      // upper nibble stays zero whatever is written
      internal_osc_frequency_select <= merge(internal_osc_frequency_select, wr_byte,
                                             MASK_FREQ_SELECT);
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      internal_osc_tuning <= RST_TUNING;
    end else if (wr_take && ADDRESS == OFS_TUNING) begin
      internal_osc_tuning <= merge(internal_osc_tuning, wr_byte, MASK_TUNING);
    end
  end

  // manual force bits gathered into the enable vector order
  always_comb begin
    force_on           = '0;
    force_on[IDX_EXT]  = oscillator_manual_enable[BIT_EXT];
    force_on[IDX_FAST] = oscillator_manual_enable[BIT_FAST];
    force_on[IDX_SLOW] = oscillator_manual_enable[BIT_SLOW];
    force_on[IDX_SEC]  = oscillator_manual_enable[BIT_SEC];
    force_on[IDX_CONV] = oscillator_manual_enable[BIT_CONV];
  end

  // force bit or a request from another module turns each oscillator on
  generate
    for (genvar i = 0; i < NUM_OSC; i++) begin : g_en
      assign next_enable[i] = force_on[i] | req_sync[i];
    end
  endgenerate

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      OSC_ENABLE   <= '0;
      EXT_OSC_MODE <= '0;
    end else begin
      OSC_ENABLE   <= next_enable;
      EXT_OSC_MODE <= mode_sync;
    end
  end

  assign freq.code   = internal_osc_frequency_select[CODE_W-1:0];
  assign freq.source = src_sync;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      FAST_OSC_FREQ_CODE <= RST_FREQ_SELECT[CODE_W-1:0];
      FAST_OSC_MHZ       <= MHZ_16;
      FAST_OSC_PLL_2X    <= 1'b0;
      FAST_OSC_RESERVED  <= 1'b0;
    end else begin
      FAST_OSC_FREQ_CODE <= freq.code;
      FAST_OSC_MHZ       <= freq.mhz;
      FAST_OSC_PLL_2X    <= freq.pll;
      FAST_OSC_RESERVED  <= freq.reserved;
    end
  end

  // signed trim plus bias gives a ramp from 00 0000 (low) to 11 1111 (high)
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      FAST_OSC_TRIM       <= RST_TUNING[TRIM_W-1:0];
      FAST_OSC_TRIM_LEVEL <= TRIM_BIAS;
    end else begin
      FAST_OSC_TRIM       <= internal_osc_tuning[TRIM_W-1:0];
      FAST_OSC_TRIM_LEVEL <= internal_osc_tuning[TRIM_W-1:0] ^ TRIM_BIAS;
    end
  end

  always_comb begin
    status                    = '0;
    status[NUM_OSC-1:0]       = OSC_ENABLE;
    status[STAT_PLL_BIT]      = FAST_OSC_PLL_2X;
    status[STAT_RESERVED_BIT] = FAST_OSC_RESERVED;
  end

  always_comb begin
    unique case (ADDRESS)
      OFS_MANUAL_ENABLE: next_readback = oscillator_manual_enable;
      OFS_FREQ_SELECT:   next_readback = internal_osc_frequency_select;
      OFS_TUNING:        next_readback = internal_osc_tuning;
      OFS_ENABLE_STATUS: next_readback = status;
      default:           next_readback = '0;
    endcase
  end

  // read data captured while waitrequest is still high, held through the answer
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      READDATA <= '0;
    end else if (READ && WAITREQUEST) begin
      READDATA <= {{(DATA_W-REG_W){1'b0}}, next_readback};
    end
  end
endmodule // ofs_top

// >>> logic/ofs_pkg.sv
// constants shared by the oscillator enable and frequency tune block
package ofs_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  localparam int unsigned NUM_OSC = 5;
  localparam int unsigned CODE_W = 4;
  localparam int unsigned SRC_W = 3;
  localparam int unsigned MHZ_W = 6;
  localparam int unsigned TRIM_W = 6;
  localparam int unsigned MODE_W = 3;

  // byte offsets on the register bus
  localparam logic [ADDR_W-1:0] OFS_MANUAL_ENABLE = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_FREQ_SELECT = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_TUNING = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_STATUS = 4'hC;

  // bit positions in the manual enable register
  localparam int unsigned BIT_EXT = 7;
  localparam int unsigned BIT_FAST = 6;
  localparam int unsigned BIT_SLOW = 4;
  localparam int unsigned BIT_SEC = 3;
  localparam int unsigned BIT_CONV = 2;

  // index of each oscillator in the request and enable vectors
  localparam int unsigned IDX_EXT = 4;
  localparam int unsigned IDX_FAST = 3;
  localparam int unsigned IDX_SLOW = 2;
  localparam int unsigned IDX_SEC = 1;
  localparam int unsigned IDX_CONV = 0;

  // writable bits and reset values
  localparam logic [REG_W-1:0] MASK_MANUAL_ENABLE = 8'hDC;
  localparam logic [REG_W-1:0] MASK_FREQ_SELECT = 8'h0F;
  localparam logic [REG_W-1:0] MASK_TUNING = 8'h3F;
  localparam logic [REG_W-1:0] RST_MANUAL_ENABLE = 8'h00;
  localparam logic [REG_W-1:0] RST_FREQ_SELECT = 8'h06;
  localparam logic [REG_W-1:0] RST_TUNING = 8'h00;

  // status register layout
  localparam int unsigned STAT_RESERVED_BIT = 7;
  localparam int unsigned STAT_PLL_BIT = 6;

  // clock source selections
  localparam logic [SRC_W-1:0] SRC_PLL_2X = 3'h0;
  localparam logic [SRC_W-1:0] SRC_FAST_INT = 3'h6;

  // frequency codes
  localparam logic [CODE_W-1:0] FRQ_C0 = 4'h0;
  localparam logic [CODE_W-1:0] FRQ_C1 = 4'h1;
  localparam logic [CODE_W-1:0] FRQ_C2 = 4'h2;
  localparam logic [CODE_W-1:0] FRQ_C3 = 4'h3;
  localparam logic [CODE_W-1:0] FRQ_C4 = 4'h4;
  localparam logic [CODE_W-1:0] FRQ_C5 = 4'h5;
  localparam logic [CODE_W-1:0] FRQ_C6 = 4'h6;

  // frequencies in MHz
  localparam logic [MHZ_W-1:0] MHZ_0 = 6'h00;
  localparam logic [MHZ_W-1:0] MHZ_1 = 6'h01;
  localparam logic [MHZ_W-1:0] MHZ_2 = 6'h02;
  localparam logic [MHZ_W-1:0] MHZ_4 = 6'h04;
  localparam logic [MHZ_W-1:0] MHZ_8 = 6'h08;
  localparam logic [MHZ_W-1:0] MHZ_12 = 6'h0C;
  localparam logic [MHZ_W-1:0] MHZ_16 = 6'h10;
  localparam logic [MHZ_W-1:0] MHZ_24 = 6'h18;
  localparam logic [MHZ_W-1:0] MHZ_32 = 6'h20;

  // bias that turns the signed trim into an unsigned ramp
  localparam logic [TRIM_W-1:0] TRIM_BIAS = 6'h20;
endpackage

// >>> logic/ofs_freq_if.sv
// carrier between the register block and the frequency decoder
`timescale 1ns/1ns
interface ofs_freq_if;
  logic [ofs_pkg::CODE_W-1:0] code;
  logic [ofs_pkg::SRC_W-1:0]  source;
  logic [ofs_pkg::MHZ_W-1:0]  mhz;
  logic                       reserved;
  logic                       pll;
  modport dec  (input code, input source, output mhz, output reserved, output pll);
  modport user (output code, output source, input mhz, input reserved, input pll);
endinterface

// >>> logic/ofs_freq_decode.sv
// maps the frequency code and source selection to a nominal frequency
`timescale 1ns/1ns
module ofs_freq_decode (
  ofs_freq_if.dec f
);
  import ofs_pkg::*;

  always_comb begin
    f.pll      = (f.source == SRC_PLL_2X);
    f.mhz      = MHZ_0;
    f.reserved = 1'b0;
    if (f.pll) begin
      unique case (f.code)
        FRQ_C4:  f.mhz = MHZ_16;
        FRQ_C5:  f.mhz = MHZ_24;
        FRQ_C6:  f.mhz = MHZ_32;
        default: f.reserved = 1'b1;
      endcase
    end else begin
      unique case (f.code)
        FRQ_C0:  f.mhz = MHZ_1;
        FRQ_C1:  f.mhz = MHZ_2;
        FRQ_C2:  f.reserved = 1'b1;
        FRQ_C3:  f.mhz = MHZ_4;
        FRQ_C4:  f.mhz = MHZ_8;
        FRQ_C5:  f.mhz = MHZ_12;
        FRQ_C6:  f.mhz = MHZ_16;
        default: f.mhz = MHZ_32;
      endcase
    end
  end
endmodule // ofs_freq_decode

// >>> tb/ofs_checker.sv
// port assertions for the oscillator control block
`timescale 1ns/1ns
module ofs_checker
  import ofs_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic [3:0]  ADDRESS,
  input wire logic        READ,
  input wire logic        WRITE,
  input wire logic [31:0] READDATA,
  input wire logic        WAITREQUEST,
  input wire logic [4:0]  PERIPH_REQ,
  input wire logic [2:0]  NEW_SOURCE_SELECT,
  input wire logic [2:0]  EXT_OSC_MODE_CONFIG,
  input wire logic [4:0]  OSC_ENABLE,
  input wire logic [2:0]  EXT_OSC_MODE,
  input wire logic [3:0]  FAST_OSC_FREQ_CODE,
  input wire logic [5:0]  FAST_OSC_MHZ,
  input wire logic        FAST_OSC_PLL_2X,
  input wire logic        FAST_OSC_RESERVED,
  input wire logic [5:0]  FAST_OSC_TRIM,
  input wire logic [5:0]  FAST_OSC_TRIM_LEVEL
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  wait_one_cycle_a: assert property (!WAITREQUEST |=> WAITREQUEST)
    else $error("wait low too long");
  bus_answer_a: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
    else $error("bus not answered");
  req_enable_a: assert property (
    !($past(RST) || $past(RST, 2) || $past(RST, 3))
    |-> (OSC_ENABLE | ~$past(PERIPH_REQ, 3)) == 5'h1F) else $error("request lost");
  mode_follow_a: assert property (
    (!RST && $stable(EXT_OSC_MODE_CONFIG))[*5] |-> EXT_OSC_MODE == EXT_OSC_MODE_CONFIG)
    else $error("mode not passed");
  pll_follow_a: assert property (
    (!RST && $stable(NEW_SOURCE_SELECT))[*5]
    |-> FAST_OSC_PLL_2X == (NEW_SOURCE_SELECT == SRC_PLL_2X)) else $error("pll flag");
  reserved_flag_a: assert property (
    ($stable(FAST_OSC_FREQ_CODE) && $stable(FAST_OSC_PLL_2X))[*3]
    |-> FAST_OSC_RESERVED == (FAST_OSC_MHZ == MHZ_0)
        && FAST_OSC_RESERVED == (FAST_OSC_PLL_2X
          ? !(FAST_OSC_FREQ_CODE == FRQ_C4 || FAST_OSC_FREQ_CODE == FRQ_C5
              || FAST_OSC_FREQ_CODE == FRQ_C6)
          : FAST_OSC_FREQ_CODE == FRQ_C2))
    else $error("reserved flag");
  trim_level_a: assert property (
    $stable(FAST_OSC_TRIM)[*2]
    |-> FAST_OSC_TRIM_LEVEL == {~FAST_OSC_TRIM[5], FAST_OSC_TRIM[4:0]})
    else $error("trim level");
  freq_read_a: assert property (
    READ && !WAITREQUEST && ADDRESS == OFS_FREQ_SELECT |-> READDATA[31:4] == 28'h0)
    else $error("upper bits");
endmodule // ofs_checker

// >>> tb/ofs_bench.sv
// self-checking bench for the oscillator control block
`timescale 1ns/1ns
module ofs_bench;
  import ofs_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  address = 4'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'hF;
  logic [4:0]  periph_req = 5'h00;
  logic [2:0]  new_src = 3'h6;
  logic [2:0]  mode_cfg = 3'h0;
  logic [31:0] readdata, q;
  logic        waitrequest, pll, rsv;
  logic [4:0]  osc_enable, e;
  logic [2:0]  ext_mode;
  logic [3:0]  freq_code;
  logic [5:0]  mhz, trim, trim_lvl, t;
  logic [7:0]  m;
  logic [5:0]  nom [8] = '{6'h01, 6'h02, 6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h20};
  logic [5:0]  tc [4] = '{6'h1F, 6'h20, 6'h3F, 6'h00};
  logic [3:0]  ra [4] = '{4'h0, 4'h4, 4'h8, 4'h2};
  logic [7:0]  rv [4] = '{8'h00, 8'h06, 8'h00, 8'h00};
  int          fb [5] = '{7, 6, 4, 3, 2};
  int          error_cnt = 0;
  int          n_compared = 0;
  always #50 clk = ~clk;
  ofs_top ofs_top_i (.CLK(clk), .RST(rst), .ADDRESS(address), .READ(read), .WRITE(write),
    .WRITEDATA(writedata), .BYTEENABLE(byteenable), .READDATA(readdata),
    .WAITREQUEST(waitrequest), .PERIPH_REQ(periph_req), .NEW_SOURCE_SELECT(new_src),
    .EXT_OSC_MODE_CONFIG(mode_cfg), .OSC_ENABLE(osc_enable), .EXT_OSC_MODE(ext_mode),
    .FAST_OSC_FREQ_CODE(freq_code), .FAST_OSC_MHZ(mhz), .FAST_OSC_PLL_2X(pll),
    .FAST_OSC_RESERVED(rsv), .FAST_OSC_TRIM(trim), .FAST_OSC_TRIM_LEVEL(trim_lvl));
  function automatic logic [5:0] exp_mhz(input logic p, input logic [3:0] c);
    if (p) return (c == 4'h4) ? 6'h10 : (c == 4'h5) ? 6'h18 : (c == 4'h6) ? 6'h20 : 6'h00;
    return c[3] ? 6'h20 : nom[c[2:0]];
  endfunction
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // holds the request until waitrequest is seen low, then releases
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    read <= ~w;
    write <= w;
    address <= a;
    writedata <= {24'($urandom()), d};
    byteenable <= be;
    // waitrequest and readdata are seen as they stood at this rising edge
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    if (waitrequest !== 1'b0) begin
      error_cnt++;
      $display("BAD %0t bus hang", $time);
      finish_test();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  initial begin
    void'($urandom(50224));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, ra[i], 8'h00, 4'hF);
      check(q, {24'h0, rv[i]});
    end
    check(32'({mhz, trim_lvl}), 32'({6'h10, 6'h20}));
    $display("test reset done");
    for (int k = 0; k < 13; k++) begin
      m = (k < 5) ? 8'h01 << fb[k] : 8'($urandom());
      e = (k < 5) ? 5'h00 : 5'($urandom());
      periph_req <= e;
      mode_cfg <= 3'($urandom());
      bus(1'b1, OFS_MANUAL_ENABLE, m, 4'hF);
      bus(1'b0, OFS_MANUAL_ENABLE, 8'h00, 4'hF);
      check(q, {24'h0, m & 8'hDC});
      bus(1'b0, OFS_ENABLE_STATUS, 8'h00, 4'hF);
      e = e | {m[7], m[6], m[4], m[3], m[2]};
      check(q, {27'h0, e});
      check(32'({osc_enable, ext_mode}), 32'({e, mode_cfg}));
    end
    $display("test enables done");
    for (int s = 0; s < 3; s++) begin
      for (int c = 0; c < 16; c++) begin
        new_src <= (s == 0) ? 3'h6 : (s == 1) ? 3'h0 : 3'($urandom_range(7, 1));
        bus(1'b1, OFS_FREQ_SELECT, {4'($urandom()), 4'(c)}, 4'hF);
        bus(1'b0, OFS_FREQ_SELECT, 8'h00, 4'hF);
        check(q, {28'h0, 4'(c)});
        t = exp_mhz(s == 1, 4'(c));
        check(32'(mhz), 32'(t));
        check(32'({rsv, pll, freq_code}), 32'({t == 6'h00, s == 1, 4'(c)}));
      end
    end
    $display("test frequency done");
    for (int i = 0; i < 8; i++) begin
      t = (i < 4) ? tc[i] : 6'($urandom());
      bus(1'b1, OFS_TUNING, {2'($urandom()), t}, 4'hF);
      bus(1'b0, OFS_TUNING, 8'h00, 4'hF);
      check(q, {26'h0, t});
      check(32'({trim, trim_lvl}), 32'({t, ~t[5], t[4:0]}));
    end
    bus(1'b1, OFS_TUNING, 8'h15, 4'hE);
    bus(1'b1, 4'h2, 8'h15, 4'hF);
    bus(1'b0, OFS_TUNING, 8'h00, 4'hF);
    check(q, {26'h0, t});
    $display("test trim done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(32'({mhz, trim_lvl}), 32'({6'h10, 6'h20}));
    bus(1'b0, OFS_FREQ_SELECT, 8'h00, 4'hF);
    check(q, 32'h06);
    $display("test second reset done");
    finish_test();
  end
endmodule // ofs_bench
bind ofs_top ofs_checker ofs_checker_i (.CLK(CLK), .RST(RST), .ADDRESS(ADDRESS), .READ(READ),
  .WRITE(WRITE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .PERIPH_REQ(PERIPH_REQ),
  .NEW_SOURCE_SELECT(NEW_SOURCE_SELECT), .EXT_OSC_MODE_CONFIG(EXT_OSC_MODE_CONFIG),
  .OSC_ENABLE(OSC_ENABLE), .EXT_OSC_MODE(EXT_OSC_MODE), .FAST_OSC_MHZ(FAST_OSC_MHZ),
  .FAST_OSC_FREQ_CODE(FAST_OSC_FREQ_CODE), .FAST_OSC_PLL_2X(FAST_OSC_PLL_2X),
  .FAST_OSC_RESERVED(FAST_OSC_RESERVED), .FAST_OSC_TRIM(FAST_OSC_TRIM),
  .FAST_OSC_TRIM_LEVEL(FAST_OSC_TRIM_LEVEL));
